// *** hdl/dps_defines.vh ***
// constants of the drive protection supervisor: register map, reset values,
// protection levels and timing counts.
// assumes a 25 MHz core clock and sensor words produced on that clock.
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define DPS_REG_CTRL 8'h00
`define DPS_REG_BRAKE_THR 8'h04
`define DPS_REG_OL_RATED 8'h08
`define DPS_REG_OL_HALF 8'h0C
`define DPS_REG_OL_FIFTH 8'h10
`define DPS_REG_STATUS 8'h14
`define DPS_REG_OL_LEVEL 8'h18
`define DPS_REG_BRAKE_EFF 8'h1C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DPS_CTRL_FRAME_B 0
`define DPS_CTRL_PTC_EN 1
`define DPS_CTRL_FAN_LO 2
`define DPS_ST_OL_FAULT 0
`define DPS_ST_MOD_FAULT 1
`define DPS_ST_PTC_FAULT 2
`define DPS_ST_OL_ALARM 4
`define DPS_ST_MOD_ALARM 5
`define DPS_ST_BRAKE 8
`define DPS_ST_FAN 9
`define DPS_ST_OL_OFF 10

// ---------------------------------------------------------------
// fan modes
// ---------------------------------------------------------------
`define DPS_FAN_OFF 2'd0
`define DPS_FAN_ON 2'd1
`define DPS_FAN_AUTO 2'd2

// ---------------------------------------------------------------
// brake levels, volts
// ---------------------------------------------------------------
`define DPS_BRAKE_SET_MIN 10'd325
`define DPS_BRAKE_SET_MAX 10'd460
`define DPS_BRAKE_RESET 10'd365
`define DPS_LINK_OV_V 410
`define DPS_BRAKE_MARGIN_PCT 15
// lowest effective level, rounded up: 348.5 V becomes 349 V
`define DPS_BRAKE_BAND_LO ((`DPS_LINK_OV_V*(100-`DPS_BRAKE_MARGIN_PCT)+99)/100)
`define DPS_BRAKE_BAND_HI `DPS_LINK_OV_V

// ---------------------------------------------------------------
// overload, current in hundredths of inverter rated current
// ---------------------------------------------------------------
`define DPS_OL_THR_MIN 8'd10
`define DPS_OL_THR_MAX 8'd200
`define DPS_OL_THR_RESET 8'd120
`define DPS_SPEED_HALF_PCT 8'd50
`define DPS_SPEED_RATED_PCT 8'd100
`define DPS_OL_ALARM_PERMILLE 63
`define DPS_OL_TRIP_S 60
`define DPS_OL_TRIP_PCT 150
`define DPS_TICK_US 1000
`define DPS_CLK_MHZ 25
`define DPS_TICK_CYC (`DPS_TICK_US*`DPS_CLK_MHZ)
// level at full scale per threshold unit: excess (thr/2) times trip ticks
`define DPS_OL_FULL_K ((`DPS_OL_TRIP_S*1000000/`DPS_TICK_US)*(`DPS_OL_TRIP_PCT-100)/100)

// ---------------------------------------------------------------
// temperatures in tenths of a degree, sensor voltage in millivolts
// ---------------------------------------------------------------
`define DPS_TEMP_A_ALARM 12'd900
`define DPS_TEMP_A_FAULT 12'd1000
`define DPS_TEMP_B_ALARM 12'd1160
`define DPS_TEMP_B_FAULT 12'd1260
`define DPS_FAN_ON_MARGIN 12'd100
`define DPS_FAN_HYST 12'd50
`define DPS_PTC_HI_MV 14'd9100
`define DPS_PTC_LO_MV 14'd1300

`endif

// *** hdl/dps_ixt_core.v ***
// overload integrator: accumulates current above the selected threshold,
// decays below it, and flags alarm and trip levels.
// assumes a one-cycle tick at the integration rate from the parent.
`timescale 1ns/1ps
`include "dps_defines.vh"

module dps_ixt_core #(
	parameter ACC_W = 24,
	parameter CUR_W = 9,
	parameter THR_W = 8
) (
	// clock and reset
	input wire core_clk_i,
	input wire rst_i,
	// integration control
	input wire tick_i,
	input wire disable_i,
	input wire [CUR_W-1:0] current_i,
	input wire [THR_W-1:0] thr_i,
	// restore from nonvolatile store
	input wire restore_i,
	input wire [ACC_W-1:0] restore_level_i,
	// results
	output reg [ACC_W-1:0] level_o,
	output reg alarm_o,
	output reg trip_o
);

	// ---------------------------------------------------------------
	// level arithmetic
	// ---------------------------------------------------------------
	localparam [ACC_W-1:0] ACC_MAX = {ACC_W{1'b1}};
	localparam [ACC_W-1:0] FULL_K = `DPS_OL_FULL_K;
	localparam [39:0] ALARM_PM = `DPS_OL_ALARM_PERMILLE;

	wire above; // current strictly over threshold
	wire [CUR_W:0] diff_up; // excess current
	wire [CUR_W:0] diff_dn; // margin below threshold
	wire [ACC_W:0] sum_up; // level plus excess, one spare bit
	wire [ACC_W-1:0] full; // 100 percent level for this threshold
	wire [39:0] lvl_pm; // level times 1000
	wire [39:0] alarm_lim; // full level times alarm permille

	assign above = current_i > {{(CUR_W-THR_W){1'b0}}, thr_i};
	assign diff_up = {1'b0, current_i} - {{(CUR_W-THR_W+1){1'b0}}, thr_i};
	assign diff_dn = {{(CUR_W-THR_W+1){1'b0}}, thr_i} - {1'b0, current_i};
	assign sum_up = {1'b0, level_o} + {{(ACC_W-CUR_W){1'b0}}, diff_up};
	assign full = {{(ACC_W-THR_W){1'b0}}, thr_i} * FULL_K;
	assign lvl_pm = {{(40-ACC_W){1'b0}}, level_o} * 40'd1000;
	assign alarm_lim = {{(40-ACC_W){1'b0}}, full} * ALARM_PM;

	// integrator: rises with excess, falls with margin, never wraps
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			level_o <= {ACC_W{1'b0}};
		end else if (restore_i) begin
			level_o <= restore_level_i;
		end else if (tick_i && !disable_i) begin
			if (above) begin
				// saturate rather than wrap to a cool reading
				level_o <= sum_up[ACC_W] ? ACC_MAX : sum_up[ACC_W-1:0];
			end else if (level_o > {{(ACC_W-CUR_W-1){1'b0}}, diff_dn}) begin
				level_o <= level_o - {{(ACC_W-CUR_W-1){1'b0}}, diff_dn};
			end else begin
				level_o <= {ACC_W{1'b0}};
			end
		end
	end

	// alarm and trip flags, registered
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			alarm_o <= 1'b0;
			trip_o <= 1'b0;
		end else begin
			alarm_o <= !disable_i && (level_o != {ACC_W{1'b0}}) &&
				(lvl_pm >= alarm_lim);
			// a trip also needs present excess: no fault while below
			trip_o <= !disable_i && above && (level_o >= full);
		end
	end

endmodule

// *** hdl/dps_supervisor.v ***
// drive protection supervisor top: brake chopper, motor overload,
// module and motor overtemperature, fan control, register port.
// assumes sensor words are produced by converter logic on core_clk_i,
// and that a nonvolatile store outside saves nv_level_o and
// presents it back with a restore strobe after power-up.
`timescale 1ns/1ps
`include "dps_defines.vh"

module dps_supervisor #(
	parameter TICK_CYCLES = `DPS_TICK_CYC,
	parameter ACC_W = 24
) (
	// clock and reset
	input wire core_clk_i,
	input wire rst_i,
	// register port
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	// sensor words
	input wire [9:0] link_voltage_i,
	input wire [8:0] out_current_i,
	input wire [7:0] out_speed_pct_i,
	input wire [11:0] module_temperature_i,
	input wire [13:0] ptc_voltage_i,
	// nonvolatile overload level
	input wire nv_restore_i,
	input wire [ACC_W-1:0] nv_level_i,
	output wire [ACC_W-1:0] nv_level_o,
	// power stage
	output reg brake_switch_o,
	output reg gate_block_o,
	output reg fan_on_o,
	// protection indications
	output wire motor_overload_alarm_o,
	output wire module_overtemp_alarm_o,
	output wire motor_overload_fault_o,
	output wire module_overtemp_fault_o,
	output wire motor_overtemp_fault_o
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// clamp a written value into its adjustable range
	function [9:0] clamp10;
		input [31:0] v;
		input [9:0] lo;
		input [9:0] hi;
		begin
			if (v < {22'h00_0000, lo})
				clamp10 = lo;
			else if (v > {22'h00_0000, hi})
				clamp10 = hi;
			else
				clamp10 = v[9:0];
		end
	endfunction

	localparam [9:0] BAND_LO = `DPS_BRAKE_BAND_LO;
	localparam [9:0] BAND_HI = `DPS_BRAKE_BAND_HI;
	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	reg frame_b_q; // power module frame B limits
	reg ptc_en_q; // analog input used for motor sensor
	reg [1:0] fan_mode_q; // fan_mode setting
	reg [9:0] brake_threshold_q; // brake_threshold_setting, volts
	reg [7:0] ol_rated_q; // overload_thr_rated_speed
	reg [7:0] ol_half_q; // overload_thr_half_speed
	reg [7:0] ol_fifth_q; // overload_thr_fifth_speed

	wire wr_ctrl = reg_wr_i && (reg_addr_i == `DPS_REG_CTRL);
	wire wr_brake = reg_wr_i && (reg_addr_i == `DPS_REG_BRAKE_THR);
	wire wr_rated = reg_wr_i && (reg_addr_i == `DPS_REG_OL_RATED);
	wire wr_half = reg_wr_i && (reg_addr_i == `DPS_REG_OL_HALF);
	wire wr_fifth = reg_wr_i && (reg_addr_i == `DPS_REG_OL_FIFTH);
	wire wr_status = reg_wr_i && (reg_addr_i == `DPS_REG_STATUS);
	wire [1:0] wr_fan = reg_wdata_i[`DPS_CTRL_FAN_LO+1:`DPS_CTRL_FAN_LO];
	// threshold write value held in range; it always fits in 8 bits
	wire [9:0] thr_cl = clamp10(reg_wdata_i, {2'b00, `DPS_OL_THR_MIN},
		{2'b00, `DPS_OL_THR_MAX});

	// register writes; out-of-range values clamp to the adjustable range
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_b_q <= 1'b0;
			ptc_en_q <= 1'b0;
			fan_mode_q <= `DPS_FAN_AUTO;
			brake_threshold_q <= `DPS_BRAKE_RESET;
			ol_rated_q <= `DPS_OL_THR_RESET;
			ol_half_q <= `DPS_OL_THR_RESET;
			ol_fifth_q <= `DPS_OL_THR_RESET;
		end else begin
			if (wr_ctrl) begin
				frame_b_q <= reg_wdata_i[`DPS_CTRL_FRAME_B];
				ptc_en_q <= reg_wdata_i[`DPS_CTRL_PTC_EN];
				// mode code 3 is not defined: keep the old mode
				if (wr_fan != 2'd3)
					fan_mode_q <= wr_fan;
			end
			if (wr_brake)
				brake_threshold_q <= clamp10(reg_wdata_i,
					`DPS_BRAKE_SET_MIN, `DPS_BRAKE_SET_MAX);
			if (wr_rated)
				ol_rated_q <= thr_cl[7:0];
			if (wr_half)
				ol_half_q <= thr_cl[7:0];
			if (wr_fifth)
				ol_fifth_q <= thr_cl[7:0];
		end
	end

	// ---------------------------------------------------------------
	// dynamic brake
	// ---------------------------------------------------------------
	// the low edge keeps braking out of the normal link region
	wire brake_off = brake_threshold_q > BAND_HI;
	wire [9:0] brake_eff = (brake_threshold_q < BAND_LO) ?
		BAND_LO : brake_threshold_q;

	// chopper: closed while the link sits at or over the level; the
	// resistor pulls it below, which opens it again on the next edge
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			brake_switch_o <= 1'b0;
		else
			brake_switch_o <= !brake_off &&
				(link_voltage_i >= brake_eff);
	end

	// ---------------------------------------------------------------
	// motor overload
	// ---------------------------------------------------------------
	reg [31:0] tick_cnt_q; // integration period counter
	reg tick_q; // one-cycle integration tick
	reg [7:0] ol_sel; // threshold for present speed
	wire ol_off; // protection switched off by settings
	wire [ACC_W-1:0] ol_level; // integrator level
	wire ol_alarm;
	wire ol_trip;

	// integration tick
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q >= TICK_LAST) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	// threshold chosen by output speed band
	always @* begin
		if (out_speed_pct_i >= `DPS_SPEED_RATED_PCT)
			ol_sel = ol_rated_q;
		else if (out_speed_pct_i >= `DPS_SPEED_HALF_PCT)
			ol_sel = ol_half_q;
		else
			ol_sel = ol_fifth_q;
	end

	assign ol_off = (ol_rated_q >= `DPS_OL_THR_MAX) &&
		(ol_half_q >= `DPS_OL_THR_MAX) &&
		(ol_fifth_q >= `DPS_OL_THR_MAX);

	dps_ixt_core #(
		.ACC_W(ACC_W),
		.CUR_W(9),
		.THR_W(8)
	) u_ixt (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.tick_i(tick_q),
		.disable_i(ol_off),
		.current_i(out_current_i),
		.thr_i(ol_sel),
		.restore_i(nv_restore_i),
		.restore_level_i(nv_level_i),
		.level_o(ol_level),
		.alarm_o(ol_alarm),
		.trip_o(ol_trip)
	);

	assign nv_level_o = ol_level;

	// ---------------------------------------------------------------
	// module temperature and fan
	// ---------------------------------------------------------------
	wire [11:0] t_alarm = frame_b_q ? `DPS_TEMP_B_ALARM : `DPS_TEMP_A_ALARM;
	wire [11:0] t_fault = frame_b_q ? `DPS_TEMP_B_FAULT : `DPS_TEMP_A_FAULT;
	wire [11:0] fan_on_lvl = t_alarm - `DPS_FAN_ON_MARGIN;
	wire [11:0] fan_off_lvl = fan_on_lvl - `DPS_FAN_HYST;
	wire mod_alarm = module_temperature_i >= t_alarm;
	wire mod_hit = module_temperature_i >= t_fault;
	reg mod_alarm_q; // module overtemperature alarm, live
	reg ol_alarm_q; // overload alarm, live
	reg auto_fan_q; // automatic fan demand, with hysteresis

	// alarms follow their cause; hysteresis keeps the fan from chattering
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mod_alarm_q <= 1'b0;
			ol_alarm_q <= 1'b0;
			auto_fan_q <= 1'b0;
			fan_on_o <= 1'b0;
		end else begin
			mod_alarm_q <= mod_alarm;
			ol_alarm_q <= ol_alarm;
			if (module_temperature_i >= fan_on_lvl)
				auto_fan_q <= 1'b1;
			else if (module_temperature_i < fan_off_lvl)
				auto_fan_q <= 1'b0;
			case (fan_mode_q)
				`DPS_FAN_OFF: fan_on_o <= 1'b0;
				`DPS_FAN_ON: fan_on_o <= 1'b1;
				default: fan_on_o <= auto_fan_q;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// motor sensor window
	// ---------------------------------------------------------------
	wire ptc_hit = ptc_en_q && ((ptc_voltage_i > `DPS_PTC_HI_MV) ||
		(ptc_voltage_i < `DPS_PTC_LO_MV));

	// ---------------------------------------------------------------
	// latched faults
	// ---------------------------------------------------------------
	reg ol_fault_q; // motor_overload_fault
	reg mod_fault_q; // module_overtemp_fault
	reg ptc_fault_q; // motor_overtemp_fault
	wire clr_ol = wr_status && reg_wdata_i[`DPS_ST_OL_FAULT];
	wire clr_mod = wr_status && reg_wdata_i[`DPS_ST_MOD_FAULT];
	wire clr_ptc = wr_status && reg_wdata_i[`DPS_ST_PTC_FAULT];

	// faults hold until written one; a present cause wins over the clear
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ol_fault_q <= 1'b0;
			mod_fault_q <= 1'b0;
			ptc_fault_q <= 1'b0;
			gate_block_o <= 1'b0;
		end else begin
			ol_fault_q <= ol_trip | (ol_fault_q & ~clr_ol);
			mod_fault_q <= mod_hit | (mod_fault_q & ~clr_mod);
			ptc_fault_q <= ptc_hit | (ptc_fault_q & ~clr_ptc);
			// alarms are left out on purpose: they never stop the motor
			gate_block_o <= ol_fault_q | mod_fault_q | ptc_fault_q;
		end
	end

	assign motor_overload_alarm_o = ol_alarm_q;
	assign module_overtemp_alarm_o = mod_alarm_q;
	assign motor_overload_fault_o = ol_fault_q;
	assign module_overtemp_fault_o = mod_fault_q;
	assign motor_overtemp_fault_o = ptc_fault_q;

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	reg [31:0] rd_mux; // selected read word

	// read word selection; unmapped offsets read zero
	always @* begin
		rd_mux = 32'h0000_0000;
		case (reg_addr_i)
			`DPS_REG_CTRL: begin
				rd_mux[`DPS_CTRL_FRAME_B] = frame_b_q;
				rd_mux[`DPS_CTRL_PTC_EN] = ptc_en_q;
				rd_mux[`DPS_CTRL_FAN_LO+1:`DPS_CTRL_FAN_LO] = fan_mode_q;
			end
			`DPS_REG_BRAKE_THR: rd_mux[9:0] = brake_threshold_q;
			`DPS_REG_OL_RATED: rd_mux[7:0] = ol_rated_q;
			`DPS_REG_OL_HALF: rd_mux[7:0] = ol_half_q;
			`DPS_REG_OL_FIFTH: rd_mux[7:0] = ol_fifth_q;
			`DPS_REG_STATUS: begin
				rd_mux[`DPS_ST_OL_FAULT] = ol_fault_q;
				rd_mux[`DPS_ST_MOD_FAULT] = mod_fault_q;
				rd_mux[`DPS_ST_PTC_FAULT] = ptc_fault_q;
				rd_mux[`DPS_ST_OL_ALARM] = ol_alarm_q;
				rd_mux[`DPS_ST_MOD_ALARM] = mod_alarm_q;
				rd_mux[`DPS_ST_BRAKE] = brake_switch_o;
				rd_mux[`DPS_ST_FAN] = fan_on_o;
				rd_mux[`DPS_ST_OL_OFF] = ol_off;
			end
			`DPS_REG_OL_LEVEL: rd_mux[ACC_W-1:0] = ol_level;
			`DPS_REG_BRAKE_EFF: rd_mux[9:0] = brake_off ? 10'h000 : brake_eff;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data stand only in the cycle after the strobe, zero otherwise
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			reg_rdata_o <= 32'h0000_0000;
		else if (reg_rd_i)
			reg_rdata_o <= rd_mux;
		else
			reg_rdata_o <= 32'h0000_0000;
	end

endmodule

// *** dv/dps_sup_assertions.sv ***
// port checker for the drive protection supervisor
// assumes it sees every register write on the register port
`timescale 1ns/1ps
`include "dps_defines.vh"

module dps_sup_checker #(
	parameter ACC_W = 24
) (
	// clock, reset and register writes
	input wire core_clk_i,
	input wire rst_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	// sensors and level store
	input wire [9:0] link_voltage_i,
	input wire [11:0] module_temperature_i,
	input wire [13:0] ptc_voltage_i,
	input wire nv_restore_i,
	input wire [ACC_W-1:0] nv_level_i,
	input wire [ACC_W-1:0] nv_level_o,
	// outputs under check
	input wire brake_switch_o,
	input wire gate_block_o,
	input wire fan_on_o,
	input wire motor_overload_alarm_o,
	input wire module_overtemp_alarm_o,
	input wire motor_overload_fault_o,
	input wire module_overtemp_fault_o,
	input wire motor_overtemp_fault_o
);
	reg [9:0] set_q; // shadow of the clamped brake setting
	reg [3:0] ctrl_q; // shadow of the control word
	wire [9:0] lo_v = 10'(`DPS_BRAKE_BAND_LO);
	wire [9:0] eff = (set_q < lo_v) ? lo_v : set_q;
	wire brk_en = set_q <= 10'(`DPS_BRAKE_BAND_HI);
	wire [11:0] al = ctrl_q[0] ? `DPS_TEMP_B_ALARM : `DPS_TEMP_A_ALARM;
	wire [11:0] fl = ctrl_q[0] ? `DPS_TEMP_B_FAULT : `DPS_TEMP_A_FAULT;

	// shadow registers follow writes at the same edge as the design
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			set_q <= `DPS_BRAKE_RESET;
			ctrl_q <= 4'h8;
		end else if (reg_wr_i && reg_addr_i == `DPS_REG_BRAKE_THR) begin
			set_q <= (reg_wdata_i < 32'd325) ? `DPS_BRAKE_SET_MIN :
				(reg_wdata_i > 32'd460) ? `DPS_BRAKE_SET_MAX :
				reg_wdata_i[9:0];
		end else if (reg_wr_i && reg_addr_i == `DPS_REG_CTRL) begin
			ctrl_q[1:0] <= reg_wdata_i[1:0];
			// code 3 is refused, old mode kept
			if (reg_wdata_i[3:2] != 2'd3)
				ctrl_q[3:2] <= reg_wdata_i[3:2];
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_any_fault;
		motor_overload_fault_o || module_overtemp_fault_o ||
			motor_overtemp_fault_o;
	endsequence

	a_gate_on_fault: assert property (s_any_fault |=> gate_block_o)
		else $error("gating not blocked after a fault");
	a_gate_no_fault: assert property (!(motor_overload_fault_o ||
		module_overtemp_fault_o || motor_overtemp_fault_o) |=> !gate_block_o)
		else $error("gating blocked without a fault");
	a_brake_close: assert property (brk_en &&
		link_voltage_i >= eff |=> brake_switch_o)
		else $error("brake open at or above its level");
	a_brake_open: assert property (!brk_en ||
		link_voltage_i < eff |=> !brake_switch_o)
		else $error("brake closed below level or when disabled");
	a_ptc_window: assert property (ctrl_q[1] && (ptc_voltage_i >
		14'd9100 || ptc_voltage_i < 14'd1300) |=> motor_overtemp_fault_o)
		else $error("sensor voltage outside window gave no fault");
	a_module_fault: assert property (module_temperature_i >= fl
		|=> module_overtemp_fault_o)
		else $error("module temperature fault missing");
	a_module_alarm: assert property (module_overtemp_alarm_o ==
		$past(module_temperature_i >= al))
		else $error("module alarm does not follow temperature");
	a_fan_fixed: assert property (ctrl_q[3:2] != `DPS_FAN_AUTO
		|=> fan_on_o == $past(ctrl_q[2]))
		else $error("fan ignores fixed fan mode");
	a_level_restore: assert property (nv_restore_i |=>
		nv_level_o == $past(nv_level_i))
		else $error("stored level not restored");
	a_ol_alarm_first: assert property ($rose(motor_overload_fault_o)
		|-> $past(motor_overload_alarm_o))
		else $error("overload fault without alarm");
endmodule

bind dps_supervisor dps_sup_checker #(.ACC_W(ACC_W)) chk_u (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.link_voltage_i(link_voltage_i),
	.module_temperature_i(module_temperature_i),
	.ptc_voltage_i(ptc_voltage_i), .nv_restore_i(nv_restore_i),
	.nv_level_i(nv_level_i), .nv_level_o(nv_level_o),
	.brake_switch_o(brake_switch_o), .gate_block_o(gate_block_o),
	.fan_on_o(fan_on_o), .motor_overload_alarm_o(motor_overload_alarm_o),
	.module_overtemp_alarm_o(module_overtemp_alarm_o),
	.motor_overload_fault_o(motor_overload_fault_o),
	.module_overtemp_fault_o(module_overtemp_fault_o),
	.motor_overtemp_fault_o(motor_overtemp_fault_o));

// *** dv/dps_plant_model.sv ***
// plant model: dc link charged by regeneration, drained by the
// brake resistor, and the nonvolatile store of the overload level
// assumes the supervisor clock; the store survives its reset
`timescale 1ns/1ps

module dps_plant_model #(
	parameter ACC_W = 24
) (
	// clock and reset of the supervisor
	input wire core_clk_i,
	input wire rst_i,
	// dc link
	input wire regen_i,
	input wire brake_i,
	output reg [9:0] link_o,
	// level store
	input wire [ACC_W-1:0] level_i,
	input wire preset_i,
	input wire [ACC_W-1:0] preset_val_i,
	output reg restore_o,
	output reg [ACC_W-1:0] stored_o
);
	reg [1:0] hold_q = 2'd0; // edges left before tracking again
	initial begin
		link_o = 10'd339;
		restore_o = 1'b0;
		stored_o = {ACC_W{1'b0}};
	end
	// resistor drains faster than regeneration charges
	always @(posedge core_clk_i) begin
		if (brake_i)
			link_o <= link_o - 10'd3;
		else if (regen_i && link_o < 10'd450)
			link_o <= link_o + 10'd1;
		else if (!regen_i && link_o > 10'd339)
			link_o <= link_o - 10'd1;
	end
	// frozen through reset so the old level outlives the power cycle
	always @(posedge core_clk_i) begin
		restore_o <= 1'b0;
		if (rst_i) begin
			hold_q <= 2'd3;
		end else if (preset_i) begin
			stored_o <= preset_val_i;
			hold_q <= 2'd3;
		end else if (hold_q != 2'd0) begin
			hold_q <= hold_q - 2'd1;
			restore_o <= (hold_q == 2'd3);
		end else begin
			stored_o <= level_i;
		end
	end
endmodule

// *** dv/tb.sv ***
// self-checking bench for the drive protection supervisor
// assumes the plant model drives the link and the level store
`timescale 1ns/1ps
`include "dps_defines.vh"

module tb;
	reg core_clk_i = 0, rst_i = 1, wr = 0, rd = 0, regen = 0, preset = 0;
	reg [7:0] addr = 0, spd = 100;
	reg [31:0] wdata = 0, v;
	reg [8:0] cur = 0;
	reg [11:0] temp = 250, al;
	reg [13:0] ptc = 5000;
	reg [23:0] pval = 0, x;
	wire [31:0] rdata;
	wire [9:0] link;
	wire [23:0] nvl_i, nvl_o;
	wire restore, brake, gate, fan, ola, mta, olf, mtf, ptf;
	integer bad_count = 0, checks_done = 0, i, n, s, e, lat, fexp;
	localparam integer FULL = 120 * `DPS_OL_FULL_K; // thr 120 scale

	dps_supervisor #(.TICK_CYCLES(4), .ACC_W(24)) dut_u (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .link_voltage_i(link), .out_current_i(cur),
		.out_speed_pct_i(spd), .module_temperature_i(temp),
		.ptc_voltage_i(ptc), .nv_restore_i(restore), .nv_level_i(nvl_i),
		.nv_level_o(nvl_o), .brake_switch_o(brake), .gate_block_o(gate),
		.fan_on_o(fan), .motor_overload_alarm_o(ola),
		.module_overtemp_alarm_o(mta), .motor_overload_fault_o(olf),
		.module_overtemp_fault_o(mtf), .motor_overtemp_fault_o(ptf));
	dps_plant_model #(.ACC_W(24)) plant_u (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .regen_i(regen),
		.brake_i(brake), .link_o(link), .level_i(nvl_o),
		.preset_i(preset), .preset_val_i(pval), .restore_o(restore),
		.stored_o(nvl_i));

	// 25 MHz core clock
	initial begin
		forever #20 core_clk_i = ~core_clk_i;
	end

	task stop_test;
		begin
			if (bad_count == 0 && checks_done > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task chk(input [31:0] exp, input [31:0] got, input [63:0] nm);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("MISMATCH %0s exp %0h got %0h", nm, exp, got);
			end
		end
	endtask
	task cyc(input integer k);
		begin
			repeat (k) @(posedge core_clk_i);
			#1;
		end
	endtask
	task wr_reg(input [7:0] a, input [31:0] d);
		begin
			@(posedge core_clk_i);
			addr <= a;
			wdata <= d;
			wr <= 1;
			@(posedge core_clk_i);
			wr <= 0;
		end
	endtask
	task rd_reg(input [7:0] a, output [31:0] d);
		begin
			@(posedge core_clk_i);
			addr <= a;
			rd <= 1;
			@(posedge core_clk_i);
			rd <= 0;
			#1 d = rdata;
		end
	endtask
	// preset the store; the plant replays it into the supervisor
	task load(input [23:0] l);
		begin
			@(posedge core_clk_i);
			pval <= l;
			preset <= 1;
			@(posedge core_clk_i);
			preset <= 0;
			cyc(8);
		end
	endtask
	// effective brake level of a written value, 0 when disabled
	function integer f_eff(input integer d);
		integer c;
		begin
			c = d < 325 ? 325 : d > 460 ? 460 : d;
			f_eff = c > 410 ? 0 : c < 349 ? 349 : c;
		end
	endfunction
	function integer f_dflt(input integer k);
		f_dflt = k == 0 ? 8 : (k == 1 || k == 7) ? 365 : k < 5 ? 120 : 0;
	endfunction

	initial begin
		v = $urandom(32'h6c65);
		cyc(12);
		rst_i <= 0;
		// reset values, the status word skipped, one unmapped read
		for (i = 0; i < 9; i = i + 1) begin
			if (i != 5) begin
				rd_reg(4 * i, v);
				chk(f_dflt(i), v, "reg");
			end
		end
		// brake: corners below and above the band, then random settings
		for (i = 0; i < 6; i = i + 1) begin
			s = i == 0 ? 300 : i == 1 ? 410 : i == 2 ? 411 : 325 + $urandom % 136;
			e = f_eff(s);
			wr_reg(`DPS_REG_BRAKE_THR, s);
			rd_reg(`DPS_REG_BRAKE_EFF, v);
			chk(e, v, "eff");
			regen <= 1;
			n = 0;
			while (!brake && n < 200) begin
				cyc(1);
				n = n + 1;
			end
			chk(e != 0, brake, "brake");
			if (e != 0)
				chk(1, link >= e && link < e + 5, "link");
			regen <= 0;
			cyc(150);
		end
		// module temperature, frames a then b, random around the limits
		for (s = 0; s < 2; s = s + 1) begin
			wr_reg(`DPS_REG_CTRL, 8 + s);
			al = s ? `DPS_TEMP_B_ALARM : `DPS_TEMP_A_ALARM;
			lat = 0;
			fexp = 0;
			for (i = 0; i < 12; i = i + 1) begin
				@(posedge core_clk_i);
				temp <= al - 250 + $urandom % 400;
				cyc(3);
				lat = lat | (temp >= al + 100);
				fexp = temp >= al - 100 ? 1 : temp < al - 150 ? 0 : fexp;
				chk(temp >= al, mta, "alarm");
				chk(lat, mtf, "mfault");
				chk(lat, gate, "gate");
				chk(fexp, fan, "fan");
			end
			temp <= 250;
			wr_reg(`DPS_REG_STATUS, 2);
			cyc(3);
			chk(0, gate, "gate");
		end
		// fixed fan modes, refused code 3 keeps the last mode
		temp <= 850;
		for (i = 0; i < 3; i = i + 1) begin
			wr_reg(`DPS_REG_CTRL, i == 0 ? 0 : i == 1 ? 4 : 12);
			cyc(2);
			chk(i != 0, fan, "fanmode");
		end
		wr_reg(`DPS_REG_CTRL, 8);
		// motor sensor window; ignored until the input is set up
		ptc <= 9500;
		cyc(3);
		chk(0, ptf, "ptc_off");
		wr_reg(`DPS_REG_CTRL, 10);
		for (i = 0; i < 4; i = i + 1) begin
			ptc <= i == 0 ? 9101 : i == 1 ? 9100 : i == 2 ? 1300 : 1299;
			cyc(3);
			chk(i == 0 || i == 3, ptf, "ptc");
			ptc <= 5000;
			wr_reg(`DPS_REG_STATUS, 4);
			cyc(2);
		end
		// overload alarm edge at 6.3 percent of full scale
		cur <= 120;
		for (i = 0; i < 2; i = i + 1) begin
			load(FULL / 1000 * 63 - 1 + i);
			chk(FULL / 1000 * 63 - 1 + i, nvl_o, "level");
			chk(i, ola, "ol_alarm");
		end
		// just below threshold from full scale: decays, never trips
		cur <= 119;
		load(FULL);
		cyc(100);
		chk(0, olf, "olfault");
		chk(1, nvl_o < FULL, "decay");
		cur <= 180;
		n = 0;
		while (!olf && n < 60) begin
			cyc(1);
			n = n + 1;
		end
		cyc(2);
		chk(1, olf && gate, "trip");
		cur <= 0;
		wr_reg(`DPS_REG_STATUS, 1);
		cyc(2);
		chk(0, olf, "olclear");
		// 150 percent adds 60 per tick: full scale in 60000 ticks
		load(0);
		cur <= 180;
		cyc(400);
		chk(1, nvl_o % 60 == 0 && nvl_o >= 5940 && nvl_o <= 6060, "rate");
		// half speed uses its own threshold
		wr_reg(`DPS_REG_OL_HALF, 60);
		spd <= 60;
		cur <= 0;
		load(0);
		cur <= 90;
		cyc(40);
		chk(1, nvl_o > 0 && nvl_o % 30 == 0, "band");
		// power cycle: stored level comes back after reset
		cur <= 120;
		rst_i <= 1;
		cyc(3);
		x = nvl_i;
		rst_i <= 0;
		cyc(10);
		chk(x, nvl_o, "restore");
		// all thresholds at twice rated current switch overload off
		for (i = 2; i < 5; i = i + 1)
			wr_reg(4 * i, 250);
		rd_reg(`DPS_REG_OL_RATED, v);
		chk(200, v, "thr_max");
		rd_reg(`DPS_REG_STATUS, v);
		chk(1, v[10], "ol_off");
		cur <= 400;
		load(2 * FULL);
		x = nvl_o;
		cyc(40);
		chk(x, nvl_o, "ol_hold");
		chk(0, olf, "ol_none");
		stop_test;
	end
endmodule
